// ===== hdl/dcpn_fifo.v
`timescale 1ns/10ps
module dcpn_fifo #(
  parameter W  = 8,
  parameter D  = 8,
  parameter AW = 3
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // fill side
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  // drain side
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rp_r];

  always @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // dcpn_fifo

// ===== hdl/dcpn_map.vh
`ifndef DCPN_MAP_VH
`define DCPN_MAP_VH

// control, framing and field characters
`define DCPN_CH_STX    8'h02
`define DCPN_CH_ENQ    8'h05
`define DCPN_CH_ACK    8'h06
`define DCPN_CH_CR     8'h0D
`define DCPN_CH_NAK    8'h15
`define DCPN_CH_SPC    8'h20
`define DCPN_CH_PLUS   8'h2B
`define DCPN_CH_MINUS  8'h2D
`define DCPN_CH_DOT    8'h2E
`define DCPN_CH_ZERO   8'h30
`define DCPN_CH_NINE   8'h39
`define DCPN_CH_QMARK  8'h3F
`define DCPN_CH_HEX_A  8'h41

// identifier and command letters
`define DCPN_CH_PUMP   8'h50
`define DCPN_CH_SPEED  8'h53
`define DCPN_CH_ADDV   8'h56
`define DCPN_CH_CLR    8'h5A
`define DCPN_CH_HALT   8'h48
`define DCPN_CH_GO     8'h47
`define DCPN_CH_STAT   8'h49
`define DCPN_CH_TOGO   8'h45

// broadcast_address, two bcd digits
`define DCPN_BCAST     8'h99

// reply kinds
`define DCPN_R_NONE    3'h0
`define DCPN_R_ACK     3'h1
`define DCPN_R_NAK     3'h2
`define DCPN_R_STAT    3'h3
`define DCPN_R_NONUM   3'h4
`define DCPN_R_TURNS   3'h5

// latched status bit positions and power-up value
`define DCPN_ST_AUX    0
`define DCPN_ST_MERR   1
`define DCPN_ST_STOP   2
`define DCPN_ST_VOL    3
`define DCPN_ST_PWR    4
`define DCPN_ST_RESET  5'h10

// downstream transmit enable limit after numbering
`define DCPN_DS_EN_MS  100
`define DCPN_CLK_KHZ   125000

`endif

// ===== hdl/dcpn_node.v
// Functional notes
// - before a number is assigned, commands get no reply at all.
// - a new speed command replaces the stored speed.
// - direction change while running is refused with NAK; host halts first.
// - add turns to counter; overflow past maximum leaves it and gives NAK.
// - clear-count zeroes the turns counter and stops a running motor.
// - numeric fields take leading zeros, leading spaces or no padding.
// - every returned data field has a fixed, command-defined length.
// - status goes out on status command or ENQ; unnumbered reported apart.
// - latched status clears only on ACK with own address and CR.
// - good command gets ACK, or its data reply for a query; good broadcast commands get nothing.
// - any error while receiving a command gives NAK instead of ACK.
// - request-to-send rises on aux change, motor error, stop, volume, power-up.
// - ENQ while requesting blocks the downstream line buffers.
// - after blocking, the node sends the status reply.
// - ACK with own address and CR drops request and unblocks downstream.
// - a repeated ENQ makes the node send its status reply again.
// - nearest requesting node wins by blocking all nodes below it.
// - frames are STX, letter, two digits, body, CR; ENQ and reply ACK/NAK alone; host ACK is followed by P, two digits, CR.
// - on numbering, release request, open receive, ACK, then open transmit.
// - address 99 reaches every pump, and each numbered one executes it.
`timescale 1ns/10ps
`include "dcpn_map.vh"
module dcpn_node #(
  parameter        FIFO_D    = 8,
  parameter        FIFO_AW   = 3,
  parameter        CNT_W     = 24,
  parameter [31:0] DS_EN_CYC = `DCPN_DS_EN_MS * `DCPN_CLK_KHZ
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // upstream receive characters
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  input  wire        rx_parity_err,
  input  wire        rx_frame_err,
  input  wire        rx_overrun,
  // upstream transmit characters
  output reg  [7:0]  tx_data_r,
  output reg         tx_valid_r,
  input  wire        tx_ready,
  // request events, one-cycle pulses
  input  wire        aux_change,
  input  wire        motor_fault,
  input  wire        stop_key,
  input  wire        volume_done,
  // link control
  output reg         rts_r,
  output reg         ds_rx_en_r,
  output reg         ds_tx_en_r,
  // motor control and node state
  output reg         run_r,
  output reg         dir_ccw_r,
  output reg  [19:0] speed_r,
  output reg  [27:0] turns_r,
  output reg         numbered_r,
  output reg  [7:0]  node_num_r
);
  localparam P_IDLE = 3'h0;
  localparam P_ID   = 3'h1;
  localparam P_A1   = 3'h2;
  localparam P_A0   = 3'h3;
  localparam P_BODY = 3'h4;

  reg [2:0]  pst_r;
  reg        is_ack_r;
  reg [3:0]  a1_r;
  reg [3:0]  a0_r;
  reg        err_r;
  reg        nak_r;
  reg [2:0]  qry_r;
  reg        any_cmd_r;
  reg [7:0]  cmd_r;
  reg        sign_r;
  reg        frac_r_mode;
  reg [19:0] int_r;
  reg [7:0]  frac_r;
  reg [1:0]  fcnt_r;
  reg [4:0]  stat_r;
  reg        busy_r;
  reg [2:0]  rtype_r;
  reg [3:0]  ridx_r;
  reg [27:0] snap_r;
  reg        dsw_r;
  reg [CNT_W-1:0] dsc_r;

  wire [7:0] f_out_data;
  wire       f_out_valid;
  wire       f_in_ready;
  wire       f_out_ready = !tx_valid_r || tx_ready;

  function [7:0] hexc;
    input [3:0] n;
    begin
      if (n < 4'hA) hexc = `DCPN_CH_ZERO + {4'h0, n};
      else hexc = `DCPN_CH_HEX_A + {4'h0, n} - 8'h0A;
    end
  endfunction

  function [28:0] bcd_add7;
    input [27:0] a;
    input [27:0] b;
    reg   [4:0]  s;
    reg          c;
    integer      i;
    begin
      c = 1'b0;
      bcd_add7 = 29'h0;
      for (i = 0; i < 7; i = i + 1) begin
        s = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
        if (s > 5'h09) begin
          s = s + 5'h06;
          c = 1'b1;
        end else begin
          c = 1'b0;
        end
        bcd_add7[4*i+:4] = s[3:0];
      end
      bcd_add7[28] = c;
    end
  endfunction

  // {last, byte} of each reply, fixed length per kind
  function [8:0] rsp_byte;
    input [2:0]  t;
    input [3:0]  i;
    input [27:0] v;
    begin
      rsp_byte = {1'b1, `DCPN_CH_CR};
      case (t)
        `DCPN_R_ACK: rsp_byte = {1'b1, `DCPN_CH_ACK};
        `DCPN_R_NAK: rsp_byte = {1'b1, `DCPN_CH_NAK};
        `DCPN_R_STAT: begin
          case (i)
            4'h0: rsp_byte = {1'b0, `DCPN_CH_STX};
            4'h1: rsp_byte = {1'b0, `DCPN_CH_STAT};
            4'h2: rsp_byte = {1'b0, hexc(v[7:4])};
            4'h3: rsp_byte = {1'b0, hexc(v[3:0])};
            default: rsp_byte = {1'b1, `DCPN_CH_CR};
          endcase
        end
        `DCPN_R_NONUM: begin
          case (i)
            4'h0: rsp_byte = {1'b0, `DCPN_CH_STX};
            4'h1: rsp_byte = {1'b0, `DCPN_CH_PUMP};
            4'h2: rsp_byte = {1'b0, `DCPN_CH_QMARK};
            4'h3: rsp_byte = {1'b0, `DCPN_CH_ZERO};
            default: rsp_byte = {1'b1, `DCPN_CH_CR};
          endcase
        end
        `DCPN_R_TURNS: begin
          case (i)
            4'h0: rsp_byte = {1'b0, `DCPN_CH_STX};
            4'h1: rsp_byte = {1'b0, `DCPN_CH_TOGO};
            4'h2: rsp_byte = {1'b0, 4'h3, v[27:24]};
            4'h3: rsp_byte = {1'b0, 4'h3, v[23:20]};
            4'h4: rsp_byte = {1'b0, 4'h3, v[19:16]};
            4'h5: rsp_byte = {1'b0, 4'h3, v[15:12]};
            4'h6: rsp_byte = {1'b0, 4'h3, v[11:8]};
            4'h7: rsp_byte = {1'b0, `DCPN_CH_DOT};
            4'h8: rsp_byte = {1'b0, 4'h3, v[7:4]};
            4'h9: rsp_byte = {1'b0, 4'h3, v[3:0]};
            default: rsp_byte = {1'b1, `DCPN_CH_CR};
          endcase
        end
        default: rsp_byte = {1'b1, `DCPN_CH_CR};
      endcase
    end
  endfunction

  // character classes
  wire       rx_bad  = rx_parity_err || rx_frame_err || rx_overrun;
  wire       is_dig  = (rx_data >= `DCPN_CH_ZERO) &&
                       (rx_data <= `DCPN_CH_NINE);
  wire [3:0] dig     = rx_data[3:0];
  wire       is_cr   = (rx_data == `DCPN_CH_CR);
  wire       is_let  = (rx_data == `DCPN_CH_SPEED) ||
                       (rx_data == `DCPN_CH_ADDV) ||
                       (rx_data == `DCPN_CH_CLR) ||
                       (rx_data == `DCPN_CH_HALT) ||
                       (rx_data == `DCPN_CH_GO) ||
                       (rx_data == `DCPN_CH_STAT) ||
                       (rx_data == `DCPN_CH_TOGO);
  wire [7:0] addr    = {a1_r, a0_r};
  wire       own     = numbered_r && (addr == node_num_r);
  wire       bcast   = (addr == `DCPN_BCAST);
  wire       addr_ok = numbered_r && (own || bcast);
  wire       in_body = rx_valid && (pst_r == P_BODY) && !is_ack_r;
  wire       fin     = in_body && (is_let || is_cr) &&
                       (cmd_r != 8'h00);
  wire       err_now = err_r || rx_bad;
  wire       exec    = fin && addr_ok && !err_now;
  wire [28:0] vsum   = bcd_add7(turns_r, {int_r, frac_r});
  wire [7:0] st_byte = {1'b0, dir_ccw_r, run_r, stat_r};
  wire [8:0] rb      = rsp_byte(rtype_r, ridx_r, snap_r);
  wire       enq_hit = rx_valid && (rx_data == `DCPN_CH_ENQ) && rts_r;

  reg        fin_nak;
  reg [2:0]  fin_qry;
  reg [2:0]  rsel;
  reg        assign_num;
  reg        release_rq;

  always @* begin
    fin_nak = 1'b0;
    fin_qry = `DCPN_R_NONE;
    if (exec) begin
      if (cmd_r == `DCPN_CH_SPEED)
        fin_nak = run_r && (sign_r != dir_ccw_r);
      else if (cmd_r == `DCPN_CH_ADDV)
        fin_nak = vsum[28];
      else if (cmd_r == `DCPN_CH_STAT)
        fin_qry = `DCPN_R_STAT;
      else if (cmd_r == `DCPN_CH_TOGO)
        fin_qry = `DCPN_R_TURNS;
    end
  end

  // reply choice at end of frame or on enquiry
  always @* begin
    rsel       = `DCPN_R_NONE;
    assign_num = 1'b0;
    release_rq = 1'b0;
    if (enq_hit) begin
      rsel = numbered_r ? `DCPN_R_STAT : `DCPN_R_NONUM;
    end else if (rx_valid && is_cr && pst_r == P_BODY) begin
      if (is_ack_r) begin
        release_rq = own && !err_now;
      end else if (!numbered_r) begin
        if (!any_cmd_r && rts_r && !ds_rx_en_r) begin
          if (err_now) rsel = `DCPN_R_NAK;
          else begin
            rsel       = `DCPN_R_ACK;
            assign_num = 1'b1;
          end
        end
      end else if (addr_ok) begin
        if (err_now) rsel = `DCPN_R_NAK;
        else if (nak_r || fin_nak) rsel = `DCPN_R_NAK;
        else if (bcast) rsel = `DCPN_R_NONE;
        else if (fin_qry != `DCPN_R_NONE) rsel = fin_qry;
        else if (qry_r != `DCPN_R_NONE) rsel = qry_r;
        else rsel = `DCPN_R_ACK;
      end
    end
  end

  // frame parser and command execution
  always @(posedge clk) begin
    if (rst) begin
      pst_r       <= P_IDLE;
      is_ack_r    <= 1'b0;
      a1_r        <= 4'h0;
      a0_r        <= 4'h0;
      err_r       <= 1'b0;
      nak_r       <= 1'b0;
      qry_r       <= `DCPN_R_NONE;
      any_cmd_r   <= 1'b0;
      cmd_r       <= 8'h00;
      sign_r      <= 1'b0;
      frac_r_mode <= 1'b0;
      int_r       <= 20'h0;
      frac_r      <= 8'h00;
      fcnt_r      <= 2'h0;
      run_r       <= 1'b0;
      dir_ccw_r   <= 1'b0;
      speed_r     <= 20'h0;
      turns_r     <= 28'h0;
      numbered_r  <= 1'b0;
      node_num_r  <= 8'h00;
    end else if (rx_valid) begin
      if (rx_data == `DCPN_CH_STX ||
          rx_data == `DCPN_CH_ACK) begin
        pst_r     <= P_ID;
        is_ack_r  <= (rx_data == `DCPN_CH_ACK);
        err_r     <= rx_bad;
        nak_r     <= 1'b0;
        qry_r     <= `DCPN_R_NONE;
        any_cmd_r <= 1'b0;
        cmd_r     <= 8'h00;
      end else if (rx_data == `DCPN_CH_ENQ) begin
        pst_r <= P_IDLE;
      end else begin
        if (rx_bad) err_r <= 1'b1;
        case (pst_r)
          P_ID: begin
            if (rx_data != `DCPN_CH_PUMP) err_r <= 1'b1;
            pst_r <= P_A1;
          end
          P_A1: begin
            if (!is_dig) err_r <= 1'b1;
            a1_r  <= dig;
            pst_r <= P_A0;
          end
          P_A0: begin
            if (!is_dig) err_r <= 1'b1;
            a0_r  <= dig;
            pst_r <= P_BODY;
          end
          P_BODY: begin
            if (is_cr) begin
              pst_r <= P_IDLE;
            end else if (is_ack_r) begin
              err_r <= 1'b1;
            end else if (is_let) begin
              any_cmd_r   <= 1'b1;
              cmd_r       <= rx_data;
              sign_r      <= dir_ccw_r;
              frac_r_mode <= 1'b0;
              int_r       <= 20'h0;
              frac_r      <= 8'h00;
              fcnt_r      <= 2'h0;
            end else if (rx_data == `DCPN_CH_PLUS) begin
              sign_r <= 1'b0;
            end else if (rx_data == `DCPN_CH_MINUS) begin
              sign_r <= 1'b1;
            end else if (rx_data == `DCPN_CH_DOT) begin
              frac_r_mode <= 1'b1;
            end else if (is_dig && !frac_r_mode) begin
              if (int_r[19:16] != 4'h0) err_r <= 1'b1;
              int_r <= {int_r[15:0], dig};
            end else if (is_dig) begin
              if (fcnt_r == 2'h0) frac_r[7:4] <= dig;
              else if (fcnt_r == 2'h1) frac_r[3:0] <= dig;
              if (fcnt_r != 2'h2) fcnt_r <= fcnt_r + 2'h1;
            end else if (rx_data != `DCPN_CH_SPC) begin
              err_r <= 1'b1;
            end
          end
          default: pst_r <= P_IDLE;
        endcase
      end
      if (fin_nak) nak_r <= 1'b1;
      if (fin_qry != `DCPN_R_NONE) qry_r <= fin_qry;
      if (exec && !fin_nak) begin
        case (cmd_r)
          `DCPN_CH_SPEED: begin
            speed_r   <= {int_r[15:0], frac_r[7:4]};
            dir_ccw_r <= sign_r;
          end
          `DCPN_CH_ADDV: turns_r <= vsum[27:0];
          `DCPN_CH_CLR: begin
            turns_r <= 28'h0;
            run_r   <= 1'b0;
          end
          `DCPN_CH_HALT: run_r <= 1'b0;
          `DCPN_CH_GO: run_r <= 1'b1;
          default: run_r <= run_r;
        endcase
      end
      if (assign_num) begin
        numbered_r <= 1'b1;
        node_num_r <= addr;
      end
    end
  end

  // request line, latched status, downstream buffers
  always @(posedge clk) begin
    if (rst) begin
      rts_r      <= 1'b1;
      stat_r     <= `DCPN_ST_RESET;
      ds_rx_en_r <= 1'b1;
      ds_tx_en_r <= 1'b1;
      dsw_r      <= 1'b0;
      dsc_r      <= {CNT_W{1'b0}};
    end else begin
      if (release_rq) begin
        rts_r      <= 1'b0;
        ds_rx_en_r <= 1'b1;
        ds_tx_en_r <= 1'b1;
      end else if (assign_num) begin
        rts_r      <= 1'b0;
        ds_rx_en_r <= 1'b1;
        dsw_r      <= 1'b1;
        dsc_r      <= {CNT_W{1'b0}};
      end else if (enq_hit) begin
        ds_rx_en_r <= 1'b0;
        ds_tx_en_r <= 1'b0;
        dsw_r      <= 1'b0;
      end else if (dsw_r) begin
        dsc_r <= dsc_r + 1'b1;
        if ((!busy_r && !f_out_valid && !tx_valid_r) ||
            dsc_r == DS_EN_CYC[CNT_W-1:0] - 1'b1) begin
          ds_tx_en_r <= 1'b1;
          dsw_r      <= 1'b0;
        end
      end
      // a new event wins over a clear in the same cycle
      if (aux_change || motor_fault || stop_key || volume_done)
        rts_r <= 1'b1;
      stat_r <= (release_rq ? 5'h00 : stat_r) |
                {1'b0, volume_done, stop_key, motor_fault, aux_change};
    end
  end

  // reply sequencer feeding the transmit fifo
  always @(posedge clk) begin
    if (rst) begin
      busy_r  <= 1'b0;
      rtype_r <= `DCPN_R_NONE;
      ridx_r  <= 4'h0;
      snap_r  <= 28'h0;
    end else if (busy_r) begin
      if (f_in_ready) begin
        ridx_r <= ridx_r + 4'h1;
        if (rb[8]) busy_r <= 1'b0;
      end
    end else if (rsel != `DCPN_R_NONE) begin
      busy_r  <= 1'b1;
      rtype_r <= rsel;
      ridx_r  <= 4'h0;
      snap_r  <= (rsel == `DCPN_R_TURNS) ?
                 (fin_qry == `DCPN_R_TURNS ? turns_r : turns_r) :
                 {20'h0, st_byte};
    end
  end

  dcpn_fifo #(
    .W  (8),
    .D  (FIFO_D),
    .AW (FIFO_AW)
  ) u_txq (
    .clk       (clk),
    .rst       (rst),
    .in_data   (rb[7:0]),
    .in_valid  (busy_r),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  always @(posedge clk) begin
    if (rst) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
    end else if (f_out_ready) begin
      tx_valid_r <= f_out_valid;
      if (f_out_valid) tx_data_r <= f_out_data;
    end
  end
endmodule // dcpn_node

// ===== verification/dcpn_host_sink.sv
`timescale 1ns/10ps
module dcpn_host_sink (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // reply handshake
  output reg  tx_ready_r,
  // pacing
  input  wire stall_en,
  input  wire stall_bit
);
  // slow host takes replies only on some edges
  always @(posedge clk) begin
    if (rst) begin
      tx_ready_r <= 1'b0;
    end else begin
      tx_ready_r <= !(stall_en && stall_bit);
    end
  end
endmodule // dcpn_host_sink

// ===== verification/dcpn_node_chk.sv
`timescale 1ns/10ps
module dcpn_node_chk (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // receive side
  input wire [7:0]  rx_data,
  input wire        rx_valid,
  input wire        rx_parity_err,
  input wire        rx_frame_err,
  input wire        rx_overrun,
  // transmit side
  input wire [7:0]  tx_data_r,
  input wire        tx_valid_r,
  input wire        tx_ready,
  // events
  input wire        aux_change,
  input wire        motor_fault,
  input wire        stop_key,
  input wire        volume_done,
  // link and node state
  input wire        rts_r,
  input wire        ds_rx_en_r,
  input wire        ds_tx_en_r,
  input wire        run_r,
  input wire        dir_ccw_r,
  input wire [19:0] speed_r,
  input wire [27:0] turns_r,
  input wire        numbered_r,
  input wire [7:0]  node_num_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire ok_c  = rx_valid && !rx_parity_err && !rx_frame_err && !rx_overrun;
  wire enq_c = ok_c && rx_data == 8'h05;
  wire evt   = aux_change || motor_fault || stop_key || volume_done;

  a_reset_state:
    assert property (disable iff (1'b0) rst |=> rts_r && !tx_valid_r &&
      !numbered_r && !run_r && turns_r == 28'h0000000 && ds_rx_en_r)
    else $error("bad state after reset");
  a_event_rts:
    assert property (evt |=> rts_r)
    else $error("event did not raise request");
  a_enq_blocks:
    assert property (rts_r && enq_c |=> !ds_rx_en_r && !ds_tx_en_r)
    else $error("downstream not blocked on enquiry");
  a_status_sent:
    assert property (rts_r && enq_c |-> ##[3:60] tx_valid_r &&
      tx_data_r == 8'h02)
    else $error("no reply after enquiry");
  a_quiet_unnum:
    assert property (run_r || turns_r != 28'h0000000 ||
      speed_r != 20'h00000 |-> numbered_r)
    else $error("command acted on before numbering");
  a_tx_stands:
    assert property (tx_valid_r && !tx_ready |=> tx_valid_r &&
      $stable(tx_data_r))
    else $error("reply byte dropped while stalled");
  a_num_frees:
    assert property ($rose(numbered_r) && !$past(evt) |-> !rts_r &&
      ds_rx_en_r)
    else $error("numbering did not release request");
  a_tx_reopen:
    assert property ($rose(ds_rx_en_r) && !ds_tx_en_r |-> ##[1:60]
      ds_tx_en_r)
    else $error("downstream transmit not reopened");
  a_release_frees:
    assert property (numbered_r && ok_c && rx_data == 8'h06
      ##1 ok_c && rx_data == 8'h50
      ##1 ok_c && rx_data == {4'h3, node_num_r[7:4]}
      ##1 ok_c && rx_data == {4'h3, node_num_r[3:0]}
      ##1 ok_c && rx_data == 8'h0D && !evt
      |=> !rts_r && ds_rx_en_r && ds_tx_en_r)
    else $error("release frame ignored");
endmodule // dcpn_node_chk

bind dcpn_node dcpn_node_chk dcpn_node_chk_i (
  .clk(clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
  .rx_overrun(rx_overrun), .tx_data_r(tx_data_r),
  .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
  .aux_change(aux_change), .motor_fault(motor_fault),
  .stop_key(stop_key), .volume_done(volume_done), .rts_r(rts_r),
  .ds_rx_en_r(ds_rx_en_r), .ds_tx_en_r(ds_tx_en_r), .run_r(run_r),
  .dir_ccw_r(dir_ccw_r), .speed_r(speed_r), .turns_r(turns_r),
  .numbered_r(numbered_r), .node_num_r(node_num_r)
);

// ===== verification/dcpn_node_tb.sv
`timescale 1ns/10ps
module dcpn_node_tb;
  // clock and stimulus
  reg         clk;
  reg         rst;
  reg  [7:0]  rx_data;
  reg         rx_valid;
  reg         rx_parity_err;
  reg         rx_frame_err;
  reg         rx_overrun;
  reg         aux_change;
  reg         motor_fault;
  reg         stop_key;
  reg         volume_done;
  reg         stall_en;
  reg         stall_bit;
  reg  [15:0] lfsr_r;
  // design and host sink outputs
  wire        tx_ready;
  wire [7:0]  tx_data_r;
  wire        tx_valid_r;
  wire        rts_r;
  wire        ds_rx_en_r;
  wire        ds_tx_en_r;
  wire        run_r;
  wire        dir_ccw_r;
  wire        numbered_r;
  wire [19:0] speed_r;
  wire [27:0] turns_r;
  wire [7:0]  node_num_r;
  logic [7:0] exp_q[$];
  int         error_cnt;
  int         n_compared;
  int         cyc;

  dcpn_node #(.DS_EN_CYC(32'h32))
  dcpn_node_i (
    .clk(clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
    .rx_overrun(rx_overrun), .tx_data_r(tx_data_r),
    .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
    .aux_change(aux_change), .motor_fault(motor_fault),
    .stop_key(stop_key), .volume_done(volume_done), .rts_r(rts_r),
    .ds_rx_en_r(ds_rx_en_r), .ds_tx_en_r(ds_tx_en_r), .run_r(run_r),
    .dir_ccw_r(dir_ccw_r), .speed_r(speed_r), .turns_r(turns_r),
    .numbered_r(numbered_r), .node_num_r(node_num_r)
  );
  dcpn_host_sink dcpn_host_sink_i (
    .clk(clk), .rst(rst), .tx_ready_r(tx_ready), .stall_en(stall_en),
    .stall_bit(stall_bit)
  );

  function automatic [15:0] lfsr_nxt(input [15:0] s);
    lfsr_nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic [2:0] e);
    @(posedge clk);
    rx_data <= b;
    rx_valid <= 1'b1;
    {rx_overrun, rx_frame_err, rx_parity_err} <= e;
  endtask

  // lead, then P, body, CR; error flags ride on the body's third char
  task automatic frame(input logic [7:0] lead, input string body,
                       input logic [2:0] e);
    send(lead, 3'h0);
    send(8'h50, 3'h0);
    for (int i = 0; i < body.len(); i++) begin
      send(body[i], (i == 2) ? e : 3'h0);
    end
    send(8'h0D, 3'h0);
    @(posedge clk);
    rx_valid <= 1'b0;
    {rx_overrun, rx_frame_err, rx_parity_err} <= 3'h0;
  endtask

  task automatic drain();
    for (int i = 0; i < 500 && exp_q.size() != 0; i++) @(posedge clk);
    check("reply queue", exp_q.size(), 0);
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic exp_str(input string s);
    exp_q.push_back(8'h02);
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
    exp_q.push_back(8'h0D);
  endtask

  task automatic do_cmd(input string body, input logic [7:0] rep);
    if (rep != 8'h00) exp_q.push_back(rep);
    frame(8'h02, body, 3'h0);
    drain();
  endtask

  // host waits for the finished reply after each enquiry
  task automatic enquire(input string s);
    exp_str(s);
    send(8'h05, 3'h0);
    @(posedge clk);
    rx_valid <= 1'b0;
    drain();
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    lfsr_r <= lfsr_nxt(lfsr_r);
    stall_bit <= lfsr_r[0];
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
    if (!rst && tx_valid_r === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) check("extra reply", tx_data_r, 32'h100);
      else check("reply byte", tx_data_r, exp_q.pop_front());
    end
  end

  initial begin
    int v;
    string pads[3];
    pads = '{"01V  200.00", "01V00200.00", "01V200.0"};
    rst = 1'b1;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    {rx_overrun, rx_frame_err, rx_parity_err} = 3'h0;
    {volume_done, stop_key, motor_fault, aux_change} = 4'h0;
    stall_en = 1'b0;
    stall_bit = 1'b0;
    lfsr_r = 16'h73E9;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("power-up request", rts_r, 1);
    do_cmd("01H", 8'h00);
    check("unnumbered", numbered_r, 0);
    $display("test unnumbered done");

    enquire("P?0");
    check("blocked", {ds_rx_en_r, ds_tx_en_r}, 0);
    enquire("P?0");
    do_cmd("01", 8'h06);
    check("numbering", {numbered_r, node_num_r, rts_r, ds_rx_en_r,
          ds_tx_en_r}, {1'b1, 8'h01, 3'b011});
    frame(8'h06, "01", 3'h0);
    drain();
    $display("test numbering done");

    stall_en <= 1'b1;
    v = lfsr_r % 10000;
    do_cmd($sformatf("01S+%04d.5", v), 8'h06);
    check("speed", speed_r, {4'(v / 1000), 4'(v / 100 % 10),
          4'(v / 10 % 10), 4'(v % 10), 4'h5});
    do_cmd("01S-0123.4", 8'h06);
    check("speed new", {dir_ccw_r, speed_r}, {1'b1, 20'h01234});
    foreach (pads[i]) begin
      do_cmd(pads[i], 8'h06);
      check("turns", turns_r, {8'h00, 4'(2 * i + 2), 16'h0000});
    end
    do_cmd("01V99999.99", 8'h15);
    check("turns kept", turns_r, 28'h0060000);
    exp_str("E00600.00");
    do_cmd("01E", 8'h00);
    do_cmd("01G", 8'h06);
    do_cmd("01S+0100.0", 8'h15);
    check("no reverse", {run_r, dir_ccw_r, speed_r},
          {2'b11, 20'h01234});
    do_cmd("01Z", 8'h06);
    check("cleared", {run_r, turns_r}, 0);
    $display("test motor commands done");

    for (int k = 0; k < 3; k++) begin
      exp_q.push_back(8'h15);
      frame(8'h02, "01H", 3'(1 << k));
      drain();
      do_cmd("01H", 8'h06);
    end
    do_cmd("99S+0200.0", 8'h00);
    check("broadcast", {dir_ccw_r, speed_r}, {1'b0, 20'h02000});
    $display("test errors and broadcast done");

    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {volume_done, stop_key, motor_fault, aux_change} <= 4'(1 << k);
      @(posedge clk);
      {volume_done, stop_key, motor_fault, aux_change} <= 4'h0;
      #1;
      check("event request", rts_r, 1);
      enquire($sformatf("I0%0d", 1 << k));
      check("event block", {ds_rx_en_r, ds_tx_en_r}, 0);
      exp_str($sformatf("I0%0d", 1 << k));
      do_cmd("01I", 8'h00);
      frame(8'h06, "01", 3'h0);
      drain();
      check("released", {rts_r, ds_rx_en_r, ds_tx_en_r}, 3'b011);
    end
    $display("test request events done");
    complete_run();
  end
endmodule // dcpn_node_tb
